// >>> design/pm_idle_timer_trap_unit.v
// peripheral power management: keyboard/mouse idle timer and trap, suspend, shadows
// How it works
// - Floppy port writes 3F2h/3F7h are captured; shadow registers return last byte.
// - Disk port writes 1F2h/1F7h are captured into two more shadow registers.
// - Suspend command write starts suspend handshake if power management bit set, no status.
// - Halted processor is released by any unmasked interrupt or management interrupt.
// - With full-suspend bit set, suspend write asserts deep suspend after halt.
// - On resume, wait programmed PLL delay before releasing suspend request.
// - With clocks stopped only enabled serial irqs and resume GPIOs wake.
// - Any write to software interrupt register raises a management interrupt.
// - Global trap enable gates all device I/O traps.
// - Global timer enable gates timers; clearing freezes, setting resumes without reload.
// - Global timer enable leaves modulation and general purpose timers alone.
// - Each idle timer is a 16-bit down counter ticking once per second.
// - On enable a timer loads, decrements next tick, first decrement never interrupts.
// - Load 1 reaches zero silently then wraps to 65535; load 2 interrupts.
// - Bus cycles in a monitored range reload the timer, which keeps counting.
// - Timer expiry interrupts only with power management bit set; timers still run.
// - Power management bit clear disables suspend command and enabled trigger events.
// - I/O addresses compare in 16 bits; memory cycles never match.
// - Keyboard ports reload the timer; mouse setting adds first or second serial range.
// - Keyboard/mouse trap bit makes any such access raise a management interrupt.
// - Keyboard/mouse events set top status bit 0 and timer or trap status bit 3.
// - Misc bit 1 means mouse on serial; bit 0 picks first or second port.
`timescale 1ns/1ps
`include "pm_idle_timer_trap_unit_regs.vh"
module pm_idle_timer_trap_unit (
   // clock and reset
   input  wire        SYS_CLK,
   input  wire        RESETN,
   // one-second timebase, synchronous one-cycle pulse
   input  wire        SECOND_TICK,
   // axi4-lite write address
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [11:0] S_AXI_AWADDR,
   // axi4-lite write data
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   // axi4-lite write response
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   output reg  [1:0]  S_AXI_BRESP,
   // axi4-lite read address
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   input  wire [11:0] S_AXI_ARADDR,
   // axi4-lite read data
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   // snooped peripheral bus cycles, one-cycle strobe
   input  wire        IO_CYCLE,
   input  wire        IO_IS_MEMORY,
   input  wire        IO_WRITE,
   input  wire [31:0] IO_ADDR,
   input  wire [7:0]  IO_WDATA,
   // processor interrupt and suspend handshake
   input  wire        UNMASKED_IRQ,
   input  wire        CPU_SUSPEND_ACK_N,
   output reg         CPU_SUSPEND_REQUEST_N,
   output reg         DEEP_SUSPEND_OUTPUT,
   // wake sources while clocks are stopped
   input  wire        SERIAL_WAKE_IRQ_A,
   input  wire        SERIAL_WAKE_IRQ_B,
   input  wire [2:0]  RESUME_GPIO,
   input  wire        CLOCKS_STOPPED,
   // management interrupt to processor
   output reg         SYS_MGMT_INTERRUPT
);

   // suspend states
   localparam [2:0] SP_IDLE   = 3'd0;
   localparam [2:0] SP_REQ    = 3'd1;
   localparam [2:0] SP_HALTED = 3'd2;
   localparam [2:0] SP_DEEP   = 3'd3;
   localparam [2:0] SP_PLL    = 3'd4;
   localparam [15:0] PLL_STEP = `PLL_STEP_CYCLES;

   // configuration and status registers
   reg  [7:0]  global_en_q, timer_en_q, trap_en_q, misc_q, gpio_resume_q, clk_stop_q;
   reg  [1:0]  serial_wake_en_q;
   reg  [7:0]  timer_stat_q, trap_stat_q, top_stat_q;
   reg  [15:0] kbm_count_q, kbm_timer_q;
   reg         kbm_first_q;
   reg  [7:0]  sh_fd_dor_q, sh_fd_rate_q, sh_hd_count_q, sh_hd_cmd_q;
   // bus slave state
   reg         aw_held_q, w_held_q;
   reg  [9:0]  aw_idx_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   // suspend machine
   reg  [2:0]  sp_state_q;
   reg  [3:0]  pll_left_q;
   reg  [15:0] pll_cyc_q;
   // wake pin synchronisers, three stages each
   reg  [4:0]  wk_s1_q, wk_s2_q, wk_s3_q;

   wire        wr_fire = aw_held_q && w_held_q && !S_AXI_BVALID;
   wire        wr_b0   = wr_fire && wstrb_q[0] && (aw_idx_q[9:8] == 2'b00);
   wire [7:0]  wr_idx  = aw_idx_q[7:0];
   wire [7:0]  wd      = wdata_q[7:0];
   wire        pm_on   = global_en_q[`BIT_PM_ENABLE];

   // io window decode, 16-bit compare for io; memory cycles never match
   wire [15:0] io_a    = IO_ADDR[15:0];
   wire        io_hit  = IO_CYCLE && !IO_IS_MEMORY;
   wire        kbd_hit = io_hit && (io_a == `PORT_KBD_DATA || io_a == `PORT_KBD_CMD);
   wire        ser1    = io_hit && (io_a[15:3] == `PORT_SER1_BASE);
   wire        ser2    = io_hit && (io_a[15:3] == `PORT_SER2_BASE);
   wire        mouse_s = misc_q[`BIT_MOUSE_ON_SERIAL];
   wire        mouse_p = misc_q[`BIT_MOUSE_PORT];
   wire        kbm_hit = kbd_hit || (mouse_s && !mouse_p && ser1)
                                 || (mouse_s && mouse_p && ser2);

   // timer gating
   wire        kbm_run    = global_en_q[`BIT_TIMERS_ENABLE] && timer_en_q[`BIT_KBM];
   wire        kbm_expire = kbm_run && SECOND_TICK && !kbm_hit && !kbm_first_q
                            && (kbm_timer_q == 16'h0001);
   wire        kbm_trap   = global_en_q[`BIT_TRAPS_ENABLE] && trap_en_q[`BIT_KBM]
                            && kbm_hit;
   wire        any_stat   = (timer_stat_q != 8'h00) || (trap_stat_q != 8'h00)
                            || (top_stat_q != 8'h00);

   // write channel acceptance, either order
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_idx_q      <= 10'h000;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= 2'b00;
      end else begin
         S_AXI_AWREADY <= !aw_held_q && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY  <= !w_held_q && !S_AXI_WREADY && S_AXI_WVALID;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_q <= 1'b1;
            aw_idx_q  <= S_AXI_AWADDR[11:2];
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA;
            wstrb_q  <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= 2'b00; // unmapped writes are ignored, answered okay
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
         end
      end
   end

   // read mux, narrow registers in low byte
   reg  [7:0] rd_byte;
   reg        rd_ok;
   always @* begin
      rd_ok   = (S_AXI_ARADDR[11:10] == 2'b00);
      rd_byte = 8'h00;
      case (S_AXI_ARADDR[9:2])
         `IDX_GLOBAL_ENABLE:   rd_byte = global_en_q;
         `IDX_TIMER_ENABLE:    rd_byte = timer_en_q;
         `IDX_TRAP_ENABLE:     rd_byte = trap_en_q;
         `IDX_TIMER_STATUS:    rd_byte = timer_stat_q;
         `IDX_TRAP_STATUS:     rd_byte = trap_stat_q;
         `IDX_MISC_CONTROL:    rd_byte = misc_q;
         `IDX_RESUME_GPIO:     rd_byte = gpio_resume_q;
         `IDX_KBM_COUNT_LO:    rd_byte = kbm_count_q[7:0];
         `IDX_KBM_COUNT_HI:    rd_byte = kbm_count_q[15:8];
         `IDX_SHADOW_FD_DOR:   rd_byte = sh_fd_dor_q;
         `IDX_SHADOW_FD_RATE:  rd_byte = sh_fd_rate_q;
         `IDX_SHADOW_HD_COUNT: rd_byte = sh_hd_count_q;
         `IDX_SHADOW_HD_CMD:   rd_byte = sh_hd_cmd_q;
         `IDX_CLOCK_STOP:      rd_byte = clk_stop_q;
         `IDX_TOP_STATUS:      rd_byte = top_stat_q;
         `IDX_SERIAL_WAKE_EN:  rd_byte = {6'h00, serial_wake_en_q};
         `IDX_SUSPEND_CMD:     rd_byte = 8'h00; // write only
         `IDX_SW_INTERRUPT:    rd_byte = 8'h00;
         default:              rd_ok   = 1'b0;
      endcase
   end

   // read channel, answer one cycle after address taken
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h00000000;
         S_AXI_RRESP   <= 2'b00;
      end else begin
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= {24'h000000, rd_byte};
            S_AXI_RRESP  <= rd_ok ? 2'b00 : 2'b10;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // configuration registers
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         global_en_q      <= `RST_BYTE;
         timer_en_q       <= `RST_BYTE;
         trap_en_q        <= `RST_BYTE;
         misc_q           <= `RST_BYTE;
         gpio_resume_q    <= `RST_BYTE;
         clk_stop_q       <= `RST_BYTE;
         serial_wake_en_q <= 2'b00;
         kbm_count_q      <= `RST_COUNT;
      end else if (wr_b0) begin
         case (wr_idx)
            `IDX_GLOBAL_ENABLE:  global_en_q      <= wd;
            `IDX_TIMER_ENABLE:   timer_en_q       <= wd;
            `IDX_TRAP_ENABLE:    trap_en_q        <= wd;
            `IDX_MISC_CONTROL:   misc_q           <= wd;
            `IDX_RESUME_GPIO:    gpio_resume_q    <= wd;
            `IDX_CLOCK_STOP:     clk_stop_q       <= wd;
            `IDX_SERIAL_WAKE_EN: serial_wake_en_q <= wd[1:0];
            `IDX_KBM_COUNT_LO:   kbm_count_q      <= {kbm_count_q[15:8], wd};
            `IDX_KBM_COUNT_HI:   kbm_count_q      <= {wd, kbm_count_q[7:0]};
            default:             global_en_q      <= global_en_q;
         endcase
      end
   end

   // port shadows: hold whatever the host last wrote, unreadable at the device
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sh_fd_dor_q   <= `RST_BYTE;
         sh_fd_rate_q  <= `RST_BYTE;
         sh_hd_count_q <= `RST_BYTE;
         sh_hd_cmd_q   <= `RST_BYTE;
      end else if (io_hit && IO_WRITE) begin
         if (io_a == `PORT_FD_DOR)   sh_fd_dor_q   <= IO_WDATA;
         if (io_a == `PORT_FD_RATE)  sh_fd_rate_q  <= IO_WDATA;
         if (io_a == `PORT_HD_COUNT) sh_hd_count_q <= IO_WDATA;
         if (io_a == `PORT_HD_CMD)   sh_hd_cmd_q   <= IO_WDATA;
      end
   end

   // keyboard/mouse idle timer; modulation and general timers live elsewhere
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         kbm_timer_q <= `RST_COUNT;
         kbm_first_q <= 1'b0;
      end else if (wr_b0 && wr_idx == `IDX_TIMER_ENABLE && wd[`BIT_KBM]
                   && !timer_en_q[`BIT_KBM]) begin
         kbm_timer_q <= kbm_count_q;
         kbm_first_q <= 1'b1;
      end else if (kbm_run) begin
         if (kbm_hit) begin
            kbm_timer_q <= kbm_count_q;
         end else if (SECOND_TICK) begin
            kbm_timer_q <= kbm_timer_q - 16'h0001;
            kbm_first_q <= 1'b0; // wraps past zero to 65535
         end
      end
      // global bit clear freezes the count, no reload on re-enable
   end

   // sticky status: set beats a simultaneous clear (write 1 to clear)
   wire clr_tm  = wr_b0 && wr_idx == `IDX_TIMER_STATUS;
   wire clr_tp  = wr_b0 && wr_idx == `IDX_TRAP_STATUS;
   wire clr_top = wr_b0 && wr_idx == `IDX_TOP_STATUS;
   wire set_tm  = kbm_expire && pm_on;
   wire set_tp  = kbm_trap && pm_on;
   wire set_sw  = wr_b0 && wr_idx == `IDX_SW_INTERRUPT;
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         timer_stat_q <= `RST_BYTE;
         trap_stat_q  <= `RST_BYTE;
         top_stat_q   <= `RST_BYTE;
      end else begin
         timer_stat_q <= (timer_stat_q & ~(clr_tm ? wd : 8'h00))
                         | {4'h0, set_tm, 3'b000};
         trap_stat_q  <= (trap_stat_q & ~(clr_tp ? wd : 8'h00))
                         | {4'h0, set_tp, 3'b000};
         top_stat_q   <= (top_stat_q & ~(clr_top ? wd : 8'h00))
                         | {6'h00, set_sw, set_tm | set_tp};
      end
   end

   // interrupt held while any status bit stays set
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) SYS_MGMT_INTERRUPT <= 1'b0;
      else SYS_MGMT_INTERRUPT <= any_stat || set_tm || set_tp || set_sw;
   end

   // wake pins: three stages, a rise counts once stages two and three agree, a fall once either drops
   wire [4:0] wk_raw = {SERIAL_WAKE_IRQ_A, SERIAL_WAKE_IRQ_B, RESUME_GPIO};
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         wk_s1_q <= 5'h00;
         wk_s2_q <= 5'h00;
         wk_s3_q <= 5'h00;
      end else begin
         wk_s1_q <= wk_raw;
         wk_s2_q <= wk_s1_q;
         wk_s3_q <= wk_s2_q;
      end
   end
   wire [4:0] wk_lvl  = wk_s2_q & wk_s3_q;
   wire       ext_wake = (wk_lvl[4] && serial_wake_en_q[0]) || (wk_lvl[3] && serial_wake_en_q[1])
                        || ((wk_lvl[2:0] & gpio_resume_q[2:0]) != 3'b000);
   // acknowledge arrives on the processor clock, same domain
   wire       int_wake = UNMASKED_IRQ || SYS_MGMT_INTERRUPT;
   wire       wake     = CLOCKS_STOPPED ? ext_wake : (int_wake || ext_wake);
   wire       cpu_suspend_request_cmd = wr_b0 && wr_idx == `IDX_SUSPEND_CMD;

   // suspend handshake machine
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sp_state_q            <= SP_IDLE;
         CPU_SUSPEND_REQUEST_N <= 1'b1;
         DEEP_SUSPEND_OUTPUT   <= 1'b0;
         pll_left_q            <= 4'h0;
         pll_cyc_q             <= 16'h0000;
      end else begin
         case (sp_state_q)
            SP_IDLE: begin
               // both paths start alike here; full suspend bit 0 is only checked after the ack
               if (cpu_suspend_request_cmd && pm_on && !any_stat) begin
                  CPU_SUSPEND_REQUEST_N <= 1'b0;
                  sp_state_q            <= SP_REQ;
               end
            end
            SP_REQ: begin
               if (!CPU_SUSPEND_ACK_N) begin
                  if (clk_stop_q[`BIT_FULL_SUSPEND]) begin
                     DEEP_SUSPEND_OUTPUT <= 1'b1;
                     sp_state_q          <= SP_DEEP;
                  end else begin
                     sp_state_q <= SP_HALTED;
                  end
               end
            end
            SP_HALTED: begin
               if (UNMASKED_IRQ || SYS_MGMT_INTERRUPT) begin
                  CPU_SUSPEND_REQUEST_N <= 1'b1;
                  sp_state_q            <= SP_IDLE;
               end
            end
            SP_DEEP: begin
               if (wake) begin
                  DEEP_SUSPEND_OUTPUT <= 1'b0;
                  pll_left_q          <= clk_stop_q[7:4];
                  pll_cyc_q           <= PLL_STEP;
                  sp_state_q          <= SP_PLL;
               end
            end
            SP_PLL: begin
               if (pll_left_q == 4'h0) begin
                  CPU_SUSPEND_REQUEST_N <= 1'b1;
                  sp_state_q            <= SP_IDLE;
               end else if (pll_cyc_q == 16'h0001) begin
                  pll_cyc_q  <= PLL_STEP;
                  pll_left_q <= pll_left_q - 4'h1;
               end else begin
                  pll_cyc_q <= pll_cyc_q - 16'h0001;
               end
            end
            default: sp_state_q <= SP_IDLE;
         endcase
      end
   end

endmodule

// >>> design/pm_idle_timer_trap_unit_regs.vh
// register map and timing counts of the idle timer/trap unit
`ifndef PM_IDLE_TIMER_TRAP_UNIT_REGS_VH
`define PM_IDLE_TIMER_TRAP_UNIT_REGS_VH
// register indexes (byte address = 4 * index)
`define IDX_GLOBAL_ENABLE   8'h80
`define IDX_TIMER_ENABLE    8'h81
`define IDX_TRAP_ENABLE     8'h82
`define IDX_TIMER_STATUS    8'h85
`define IDX_TRAP_STATUS     8'h86
`define IDX_MISC_CONTROL    8'h93
`define IDX_RESUME_GPIO     8'h92
`define IDX_KBM_COUNT_LO    8'h9e
`define IDX_KBM_COUNT_HI    8'h9f
`define IDX_SUSPEND_CMD     8'hae
`define IDX_SHADOW_FD_DOR   8'hb4
`define IDX_SHADOW_FD_RATE  8'hb5
`define IDX_SHADOW_HD_COUNT 8'hb6
`define IDX_SHADOW_HD_CMD   8'hb7
`define IDX_CLOCK_STOP      8'hbc
`define IDX_SW_INTERRUPT    8'hd0
`define IDX_TOP_STATUS      8'hf0
`define IDX_SERIAL_WAKE_EN  8'hf1
// field positions
`define BIT_PM_ENABLE       0
`define BIT_TIMERS_ENABLE   1
`define BIT_TRAPS_ENABLE    2
`define BIT_KBM             3
`define BIT_FULL_SUSPEND    0
`define BIT_MOUSE_ON_SERIAL 1
`define BIT_MOUSE_PORT      0
`define BIT_TOP_KBM         0
`define BIT_TOP_SW          1
// reset values
`define RST_BYTE            8'h00
`define RST_COUNT           16'h0000
// i/o ports watched on the peripheral bus
`define PORT_KBD_DATA       16'h0060
`define PORT_KBD_CMD        16'h0064
`define PORT_SER1_BASE      13'h007f
`define PORT_SER2_BASE      13'h005f
`define PORT_FD_DOR         16'h03f2
`define PORT_FD_RATE        16'h03f7
`define PORT_HD_COUNT       16'h01f2
`define PORT_HD_CMD         16'h01f7
// pll delay step, 1 us at 25 ns
`define CLK_PERIOD_NS       25
`define PLL_STEP_US         1
`define PLL_STEP_CYCLES     ((`PLL_STEP_US * 1000) / `CLK_PERIOD_NS)
`endif

// >>> test/cpu_ack_model.sv
// processor model answering the suspend handshake
`timescale 1ns/1ps
module cpu_ack_model #(
   parameter DELAY = 4
) (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // suspend handshake
   input  wire req_n,
   output wire ack_n
);
   reg [DELAY-1:0] dly_q;
   // ack trails the request; a slow processor is only a larger delay (at least 2)
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) dly_q <= {DELAY{1'b1}};
      else dly_q <= {dly_q[DELAY-2:0], req_n};
   end
   assign ack_n = dly_q[DELAY-1];
endmodule

// >>> test/pm_idle_timer_trap_unit_tb_top.sv
// self-checking bench of the idle timer/trap unit
`timescale 1ns/1ps
`include "pm_idle_timer_trap_unit_regs.vh"
module pm_idle_timer_trap_unit_tb_top;
   reg         clk, rst_n, tick, awvalid, wvalid, bready, arvalid, rready;
   reg         io_cyc, io_mem, io_wr, irq, wake_a, clk_stop;
   reg  [11:0] awaddr, araddr;
   reg  [31:0] wdata, io_addr, d;
   reg  [7:0]  io_wdata;
   reg  [1:0]  r;
   reg  [41:0] rows [0:6];
   reg  [63:0] sh_ports;
   wire        awready, wready, bvalid, arready, rvalid, ack_n, req_n, deep, sys_mgmt_interrupt;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   integer     failures, tests_run, i, n;
   pm_idle_timer_trap_unit u_pm_idle_timer_trap_unit (
      .SYS_CLK(clk), .RESETN(rst_n), .SECOND_TICK(tick),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .IO_CYCLE(io_cyc), .IO_IS_MEMORY(io_mem), .IO_WRITE(io_wr), .IO_ADDR(io_addr),
      .IO_WDATA(io_wdata), .UNMASKED_IRQ(irq), .CPU_SUSPEND_ACK_N(ack_n),
      .CPU_SUSPEND_REQUEST_N(req_n), .DEEP_SUSPEND_OUTPUT(deep), .SERIAL_WAKE_IRQ_A(wake_a),
      .SERIAL_WAKE_IRQ_B(1'b0), .RESUME_GPIO(3'h0), .CLOCKS_STOPPED(clk_stop),
      .SYS_MGMT_INTERRUPT(sys_mgmt_interrupt));
   cpu_ack_model #(.DELAY(4)) u_cpu_ack_model (.clk(clk), .rst_n(rst_n), .req_n(req_n),
      .ack_n(ack_n));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task stop_test;
      begin
         if (failures == 0 && tests_run > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk_val(input string name, input [31:0] exp, input [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0s exp %h got %h", name, exp, got);
         end
      end
   endtask
   task chk_bit(input string name, input exp, input got);
      chk_val(name, {31'h0, exp}, {31'h0, got});
   endtask
   // bready raised late on purpose so the slave must hold its response
   task axi_wr(input [7:0] idx, input [7:0] v);
      begin
         @(posedge clk);
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         awaddr <= {2'b00, idx, 2'b00};
         wdata <= {24'h0, v};
         n = 0;
         do begin
            @(posedge clk);
            n = n + 1;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n == 4) bready <= 1'b1;
         end while (!(bvalid && bready) && n < 100);
         failures = failures + (n >= 100);
         bready <= 1'b0;
      end
   endtask
   task axi_rd(input [7:0] idx);
      begin
         @(posedge clk);
         arvalid <= 1'b1;
         araddr <= {2'b00, idx, 2'b00};
         n = 0;
         do begin
            @(posedge clk);
            n = n + 1;
            if (arready) arvalid <= 1'b0;
            if (n == 3) rready <= 1'b1;
         end while (!(rvalid && rready) && n < 100);
         failures = failures + (n >= 100);
         d = rdata;
         r = rresp;
         rready <= 1'b0;
      end
   endtask
   task rd_chk(input [7:0] idx, input [7:0] v);
      begin
         axi_rd(idx);
         chk_val("rdata", {24'h0, v}, d);
         chk_val("rresp", 32'h0, {30'h0, r});
      end
   endtask
   task io(input m, input w, input [31:0] a, input [7:0] v);
      begin
         @(posedge clk);
         io_cyc <= 1'b1;
         io_mem <= m;
         io_wr <= w;
         io_addr <= a;
         io_wdata <= v;
         @(posedge clk);
         io_cyc <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   task sec;
      begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   // clear second-level bit 3 and both top bits
   task clr_st(input [7:0] idx);
      begin
         axi_wr(idx, 8'h08);
         axi_wr(`IDX_TOP_STATUS, 8'h03);
      end
   endtask
   task wait_req(input v);
      for (n = 0; req_n !== v && n < 400; n = n + 1) @(posedge clk);
   endtask
   initial begin
      #1000000;
      failures = failures + 1;
      stop_test;
   end
   initial begin
      {rst_n, tick, awvalid, wvalid, bready, arvalid, rready, irq, wake_a, clk_stop} = 10'h0;
      {io_cyc, io_mem, io_wr, awaddr, araddr, wdata, io_addr, io_wdata} = 99'h0;
      failures = 0;
      tests_run = 0;
      sh_ports = {`PORT_HD_CMD, `PORT_HD_COUNT, `PORT_FD_RATE, `PORT_FD_DOR};
      // memory flag, address, misc control, expected reload
      rows[0] = {1'b0, 32'h0000_0060, 8'h00, 1'b1};
      rows[1] = {1'b0, 32'h1234_0064, 8'h00, 1'b1};
      rows[2] = {1'b1, 32'h0000_0060, 8'h00, 1'b0};
      rows[3] = {1'b0, 32'h0000_03fc, 8'h02, 1'b1};
      rows[4] = {1'b0, 32'h0000_03fc, 8'h00, 1'b0};
      rows[5] = {1'b0, 32'h0000_02f8, 8'h03, 1'b1};
      rows[6] = {1'b0, 32'h0000_02ff, 8'h02, 1'b0};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk_bit("req_n", 1'b1, req_n);
      rd_chk(`IDX_GLOBAL_ENABLE, 8'h00);
      rd_chk(`IDX_TIMER_ENABLE, 8'h00);
      rd_chk(`IDX_TRAP_ENABLE, 8'h00);
      axi_rd(8'h01);
      chk_val("unmapped", 32'h2, {30'h0, r});
      // load 2: silent first tick, expiry on the second
      axi_wr(`IDX_KBM_COUNT_LO, 8'h02);
      axi_wr(`IDX_KBM_COUNT_HI, 8'h00);
      axi_wr(`IDX_GLOBAL_ENABLE, 8'h03);
      axi_wr(`IDX_TIMER_ENABLE, 8'h08);
      sec;
      rd_chk(`IDX_TIMER_STATUS, 8'h00);
      sec;
      rd_chk(`IDX_TIMER_STATUS, 8'h08);
      rd_chk(`IDX_TOP_STATUS, 8'h01);
      chk_bit("smi", 1'b1, sys_mgmt_interrupt);
      clr_st(`IDX_TIMER_STATUS);
      chk_bit("smi", 1'b0, sys_mgmt_interrupt);
      // a miss lets the timer wrap past zero: no expiry
      for (i = 0; i < 7; i = i + 1) begin
         axi_wr(`IDX_MISC_CONTROL, rows[i][8:1]);
         io(rows[i][41], 1'b0, rows[i][40:9], 8'h00);
         sec;
         rd_chk(`IDX_TIMER_STATUS, 8'h00);
         sec;
         rd_chk(`IDX_TIMER_STATUS, {4'h0, rows[i][0], 3'h0});
         clr_st(`IDX_TIMER_STATUS);
      end
      // second pass overwrites; port reads must not be captured
      for (i = 0; i < 8; i = i + 1) begin
         io(1'b0, 1'b1, {16'h0, sh_ports[16*(i%4) +: 16]}, 8'h30 + i[7:0]);
         io(1'b0, 1'b0, {16'h0, sh_ports[16*(i%4) +: 16]}, 8'hff);
         rd_chk(`IDX_SHADOW_FD_DOR + i[1:0], 8'h30 + i[7:0]);
      end
      axi_wr(`IDX_TRAP_ENABLE, 8'h08);
      axi_wr(`IDX_GLOBAL_ENABLE, 8'h07);
      io(1'b0, 1'b0, 32'h0000_0064, 8'h00);
      rd_chk(`IDX_TRAP_STATUS, 8'h08);
      rd_chk(`IDX_TOP_STATUS, 8'h01);
      clr_st(`IDX_TRAP_STATUS);
      axi_wr(`IDX_GLOBAL_ENABLE, 8'h03);
      io(1'b0, 1'b1, 32'h0000_0060, 8'h00);
      rd_chk(`IDX_TRAP_STATUS, 8'h00);
      axi_wr(`IDX_SW_INTERRUPT, 8'h5a);
      rd_chk(`IDX_TOP_STATUS, 8'h02);
      chk_bit("smi", 1'b1, sys_mgmt_interrupt);
      axi_wr(`IDX_TOP_STATUS, 8'h02);
      // suspend command ignored with power management off
      axi_wr(`IDX_GLOBAL_ENABLE, 8'h00);
      axi_wr(`IDX_SUSPEND_CMD, 8'h00);
      repeat (8) @(posedge clk);
      chk_bit("req_n", 1'b1, req_n);
      axi_wr(`IDX_GLOBAL_ENABLE, 8'h01);
      axi_wr(`IDX_SUSPEND_CMD, 8'h00);
      wait_req(1'b0);
      chk_bit("req_n", 1'b0, req_n);
      repeat (10) @(posedge clk);
      irq <= 1'b1;
      wait_req(1'b1);
      chk_bit("req_n", 1'b1, req_n);
      irq <= 1'b0;
      axi_wr(`IDX_CLOCK_STOP, 8'h11);
      axi_wr(`IDX_SERIAL_WAKE_EN, 8'h01);
      clk_stop <= 1'b1;
      axi_wr(`IDX_SUSPEND_CMD, 8'h00);
      wait_req(1'b0);
      repeat (12) @(posedge clk);
      chk_bit("deep", 1'b1, deep);
      irq <= 1'b1;
      repeat (12) @(posedge clk);
      chk_bit("deep", 1'b1, deep);
      irq <= 1'b0;
      wake_a <= 1'b1;
      for (n = 0; deep !== 1'b0 && n < 400; n = n + 1) @(posedge clk);
      wait_req(1'b1);
      chk_bit("pll", 1'b1, n >= `PLL_STEP_CYCLES - 2 && n <= `PLL_STEP_CYCLES + 2);
      wake_a <= 1'b0;
      stop_test;
   end
endmodule

// >>> test/pm_unit_checker_sva.sv
// port-level assertions for the idle timer/trap unit
`timescale 1ns/1ps
module pm_unit_checker (
   // clock and reset
   input wire        SYS_CLK,
   input wire        RESETN,
   // axi4-lite
   input wire        S_AXI_WVALID,
   input wire        S_AXI_WREADY,
   input wire        S_AXI_BVALID,
   input wire        S_AXI_BREADY,
   input wire [1:0]  S_AXI_BRESP,
   input wire        S_AXI_ARVALID,
   input wire        S_AXI_ARREADY,
   input wire        S_AXI_RVALID,
   input wire        S_AXI_RREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire [1:0]  S_AXI_RRESP,
   // processor side
   input wire        CPU_SUSPEND_ACK_N,
   input wire        CPU_SUSPEND_REQUEST_N,
   input wire        DEEP_SUSPEND_OUTPUT,
   input wire        SYS_MGMT_INTERRUPT
);
   reg [2:0] wr_age_q;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   // cycles since last write data beat, saturating
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) wr_age_q <= 3'h7;
      else if (S_AXI_WVALID && S_AXI_WREADY) wr_age_q <= 3'h0;
      else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
   end
   bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("bvalid dropped");
   rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data not held");
   read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   bresp_okay_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'b00)
      else $error("bresp not okay");
   slverr_zero_a: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'b10 |->
      S_AXI_RDATA == 32'h0) else $error("slverr with data");
   smi_clear_a: assert property ($fell(SYS_MGMT_INTERRUPT) |-> wr_age_q < 3'h6)
      else $error("smi fell unprompted");
   suspend_cause_a: assert property ($fell(CPU_SUSPEND_REQUEST_N) |-> wr_age_q < 3'h6)
      else $error("suspend unprompted");
   deep_after_ack_a: assert property ($rose(DEEP_SUSPEND_OUTPUT) |->
      !CPU_SUSPEND_ACK_N && !CPU_SUSPEND_REQUEST_N) else $error("deep suspend before halt");
endmodule
bind pm_idle_timer_trap_unit pm_unit_checker u_pm_unit_checker (.*);
